//--- design/bbfc_host.sv
module bbfc_host
   import bbfc_pkg::*;
#(
   parameter int unsigned POLL_LIMIT = 32'd1000000
) (
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   input  wire logic              req_valid_i,
   input  wire bbfc_req_t         req_i,
   output logic                   req_ready_o,
   output logic                   done_o,
   output logic                   fail_o,
   output logic [7:0]             rdata_o,
   output bbfc_pins_t             pins_o,
   input  wire logic [7:0]        dq_i
);
   typedef enum {ST_IDLE, ST_WSET, ST_WLOW, ST_WHIGH, ST_RD, ST_GAP, ST_HV, ST_DONE} bbfc_st_t;

   // number of bus writes that open each command
   function automatic logic [2:0] bbfc_nwrites(input bbfc_cmd_t c);
      case (c)
         BBFC_CMD_PROG:    return 3'h4;
         BBFC_CMD_SERASE,
         BBFC_CMD_CERASE:  return 3'h6;
         BBFC_CMD_AUTOSEL: return 3'h3;
         BBFC_CMD_RESET:   return 3'h1;
         default:          return 3'h0;
      endcase
   endfunction : bbfc_nwrites

   // address and data of write number i of a command
   function automatic logic [24:0] bbfc_word(input bbfc_req_t r, input logic [2:0] i);
      case (i)
         3'h0:    return (r.cmd == BBFC_CMD_RESET) ? {r.addr, BBFC_CODE_RESET}
                                                   : {BBFC_UNLK_ADDR1, BBFC_UNLK_DATA1};
         3'h1:    return {BBFC_UNLK_ADDR2, BBFC_UNLK_DATA2};
         3'h2:    begin
            case (r.cmd)
               BBFC_CMD_PROG:    return {BBFC_UNLK_ADDR1, BBFC_CODE_PROG};
               BBFC_CMD_AUTOSEL: return {BBFC_UNLK_ADDR1, BBFC_CODE_IDENT};
               default:          return {BBFC_UNLK_ADDR1, BBFC_CODE_ESETUP};
            endcase
         end
         3'h3:    return (r.cmd == BBFC_CMD_PROG) ? {r.addr, r.data}
                                                  : {BBFC_UNLK_ADDR1, BBFC_UNLK_DATA1};
         3'h4:    return {BBFC_UNLK_ADDR2, BBFC_UNLK_DATA2};
         default: return (r.cmd == BBFC_CMD_CERASE) ? {BBFC_UNLK_ADDR1, BBFC_CODE_CERASE}
                                                    : {r.addr, BBFC_CODE_SERASE};
      endcase
   endfunction : bbfc_word

   bbfc_st_t    state_r,  state_nxt;
   bbfc_req_t   req_r,    req_nxt;
   bbfc_pins_t  pins_r,   pins_nxt;
   logic [7:0]  cnt_r,    cnt_nxt;
   logic [2:0]  step_r,   step_nxt;
   logic [7:0]  rdata_r,  rdata_nxt;
   logic        prev6_r,  prev6_nxt;
   logic        havep_r,  havep_nxt;
   logic        fail_r,   fail_nxt;
   logic [31:0] polls_r,  polls_nxt;
   logic [7:0]  dq_s1_r;
   logic [7:0]  dq_s2_r;
   logic        polling;
   logic        expect7;
   logic [24:0] word;

   // two-stage synchroniser on the data pins
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
      end else begin
         dq_s1_r <= dq_i;
         dq_s2_r <= dq_s1_r;
      end
   end

   assign polling = (req_r.cmd == BBFC_CMD_PROG) || (req_r.cmd == BBFC_CMD_SERASE)
                    || (req_r.cmd == BBFC_CMD_CERASE);
   // erase finishes with ones, program with the true written bit
   assign expect7 = (req_r.cmd == BBFC_CMD_PROG) ? req_r.data[BBFC_POLL_BIT] : 1'b1;
   assign word    = bbfc_word(req_r, step_r);

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      req_nxt   = req_r;
      pins_nxt  = pins_r;
      cnt_nxt   = cnt_r;
      step_nxt  = step_r;
      rdata_nxt = rdata_r;
      prev6_nxt = prev6_r;
      havep_nxt = havep_r;
      fail_nxt  = fail_r;
      polls_nxt = polls_r;
      case (state_r)
         ST_IDLE: begin
            if (req_valid_i) begin
               req_nxt   = req_i;
               step_nxt  = 3'h0;
               havep_nxt = 1'b0;
               fail_nxt  = 1'b0;
               polls_nxt = 32'h0;
               if (bbfc_nwrites(req_i.cmd) != 3'h0) begin
                  state_nxt = ST_WSET;
               end else if (req_i.cmd == BBFC_CMD_READ) begin
                  state_nxt = ST_RD;
                  cnt_nxt   = BBFC_RD_CYC;
               end else begin
                  state_nxt = ST_HV;
                  cnt_nxt   = BBFC_HV_CYC;
               end
            end
         end
         ST_WSET: begin
            // address settles with CE low and WE still high
            pins_nxt       = BBFC_PINS_IDLE;
            pins_nxt.ce_n  = 1'b0;
            pins_nxt.addr  = word[24:8];
            pins_nxt.dq    = word[7:0];
            pins_nxt.dq_oe = 1'b1;
            state_nxt      = ST_WLOW;
            // one extra count: we_n only falls a cycle after the load
            cnt_nxt        = BBFC_WP_CYC + 8'h01;
         end
         ST_WLOW: begin
            pins_nxt.we_n = 1'b0;
            cnt_nxt       = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               pins_nxt.we_n = 1'b1;
               state_nxt     = ST_WHIGH;
               cnt_nxt       = BBFC_WPH_CYC;
            end
         end
         ST_WHIGH: begin
            pins_nxt = BBFC_PINS_IDLE;
            cnt_nxt  = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               step_nxt = step_r + 3'h1;
               if (step_r + 3'h1 < bbfc_nwrites(req_r.cmd)) begin
                  state_nxt = ST_WSET;
               end else if (req_r.cmd == BBFC_CMD_RESET) begin
                  state_nxt = ST_DONE;
               end else begin
                  state_nxt = ST_RD;
                  cnt_nxt   = BBFC_RD_CYC;
               end
            end
         end
         ST_RD: begin
            pins_nxt.ce_n  = 1'b0;
            pins_nxt.oe_n  = 1'b0;
            pins_nxt.we_n  = 1'b1;
            pins_nxt.dq_oe = 1'b0;
            pins_nxt.addr  = req_r.addr;
            cnt_nxt        = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               rdata_nxt = dq_s2_r;
               prev6_nxt = dq_s2_r[BBFC_TOGGLE_BIT];
               havep_nxt = 1'b1;
               pins_nxt.ce_n = 1'b1;
               pins_nxt.oe_n = 1'b1;
               // finished once bit 7 is true and bit 6 stopped toggling
               if (polling && !(dq_s2_r[BBFC_POLL_BIT] == expect7 && havep_r
                                && dq_s2_r[BBFC_TOGGLE_BIT] == prev6_r)) begin
                  polls_nxt = polls_r + 32'h1;
                  if (polls_r + 32'h1 >= POLL_LIMIT) begin
                     fail_nxt  = 1'b1;
                     state_nxt = ST_DONE;
                  end else begin
                     state_nxt = ST_GAP;
                     cnt_nxt   = BBFC_WPH_CYC;
                  end
               end else begin
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_GAP: begin
            // OE high between polls so each read is a new access
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
               state_nxt = ST_RD;
               cnt_nxt   = BBFC_RD_CYC;
            end
         end
         ST_HV: begin
            pins_nxt       = BBFC_PINS_IDLE;
            pins_nxt.addr  = req_r.addr;
            pins_nxt.hv_a9 = 1'b1;
            if (req_r.cmd == BBFC_CMD_HVID) begin
               state_nxt = ST_RD;
               cnt_nxt   = BBFC_RD_CYC;
            end else begin
               pins_nxt.we_n  = 1'b0;
               pins_nxt.hv_oe = 1'b1;
               pins_nxt.hv_ce = (req_r.cmd == BBFC_CMD_UNLOCK);
               pins_nxt.ce_n  = (req_r.cmd == BBFC_CMD_UNLOCK);
               cnt_nxt        = cnt_r - 8'h01;
               if (cnt_r == 8'h01) begin
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            pins_nxt  = BBFC_PINS_IDLE;
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            pins_nxt  = BBFC_PINS_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         req_r   <= '{BBFC_CMD_READ, 17'h00000, 8'h00};
         pins_r  <= BBFC_PINS_IDLE;
         cnt_r   <= 8'h00;
         step_r  <= 3'h0;
         rdata_r <= 8'h00;
         prev6_r <= 1'b0;
         havep_r <= 1'b0;
         fail_r  <= 1'b0;
         polls_r <= 32'h0;
      end else begin
         state_r <= state_nxt;
         req_r   <= req_nxt;
         pins_r  <= pins_nxt;
         cnt_r   <= cnt_nxt;
         step_r  <= step_nxt;
         rdata_r <= rdata_nxt;
         prev6_r <= prev6_nxt;
         havep_r <= havep_nxt;
         fail_r  <= fail_nxt;
         polls_r <= polls_nxt;
      end
   end

   assign req_ready_o = (state_r == ST_IDLE);
   assign done_o      = (state_r == ST_DONE);
   assign fail_o      = fail_r;
   assign rdata_o     = rdata_r;
   assign pins_o      = pins_r;

   // checks on the driven pins
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_we_fall;
      $fell(pins_r.we_n) && !pins_r.hv_a9;
   endsequence
   sequence s_we_held;
      !pins_r.we_n [*8];
   endsequence

   property p_no_oe_write;
      !pins_r.we_n && !pins_r.hv_a9 |-> pins_r.oe_n && !pins_r.ce_n;
   endproperty
   a_no_oe_write: assert property (p_no_oe_write) else $error("write with OE low or CE high");

   property p_pulse_width;
      s_we_fall |-> s_we_held ##1 !pins_r.we_n ##1 pins_r.we_n;
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("write pulse not nine cycles");

   property p_addr_stable;
      !pins_r.we_n && $past(!pins_r.we_n) |-> $stable(pins_r.addr) && $stable(pins_r.dq);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved in pulse");

   property p_data_at_rise;
      $rose(pins_r.we_n) && !$past(pins_r.hv_a9) |-> pins_r.dq_oe && $stable(pins_r.dq);
   endproperty
   a_data_at_rise: assert property (p_data_at_rise) else $error("data not held at rise");

   property p_prog_code;
      s_we_fall and (req_r.cmd == BBFC_CMD_PROG) and (step_r == 3'h2)
         |-> pins_r.addr == BBFC_UNLK_ADDR1 && pins_r.dq == BBFC_CODE_PROG;
   endproperty
   a_prog_code: assert property (p_prog_code) else $error("program code wrong");

   property p_cerase_code;
      s_we_fall and (req_r.cmd == BBFC_CMD_CERASE) and (step_r == 3'h5)
         |-> pins_r.addr == BBFC_UNLK_ADDR1 && pins_r.dq == BBFC_CODE_CERASE;
   endproperty
   a_cerase_code: assert property (p_cerase_code) else $error("chip erase code wrong");

   property p_serase_code;
      s_we_fall and (req_r.cmd == BBFC_CMD_SERASE) and (step_r == 3'h5)
         |-> pins_r.addr == req_r.addr && pins_r.dq == BBFC_CODE_SERASE;
   endproperty
   a_serase_code: assert property (p_serase_code) else $error("sector erase code wrong");

   property p_ident_code;
      s_we_fall and (req_r.cmd == BBFC_CMD_AUTOSEL) and (step_r == 3'h2)
         |-> pins_r.dq == BBFC_CODE_IDENT;
   endproperty
   a_ident_code: assert property (p_ident_code) else $error("identify code wrong");

   property p_reset_code;
      s_we_fall and (req_r.cmd == BBFC_CMD_RESET) |-> pins_r.dq == BBFC_CODE_RESET;
   endproperty
   a_reset_code: assert property (p_reset_code) else $error("reset code wrong");

   property p_lock_pins;
      pins_r.hv_oe && !pins_r.hv_ce |-> pins_r.hv_a9 && !pins_r.ce_n && !pins_r.we_n;
   endproperty
   a_lock_pins: assert property (p_lock_pins) else $error("lock pin set wrong");

   property p_unlock_pins;
      pins_r.hv_ce |-> pins_r.hv_oe && pins_r.hv_a9 && !pins_r.we_n;
   endproperty
   a_unlock_pins: assert property (p_unlock_pins) else $error("unlock pin set wrong");

   property p_no_write_polling;
      (state_r == ST_GAP) || (state_r == ST_RD) |-> pins_r.we_n;
   endproperty
   a_no_write_polling: assert property (p_no_write_polling) else $error("write while busy");
endmodule : bbfc_host

//--- design/bbfc_pkg.sv
package bbfc_pkg;
   // bus geometry of the attached flash
   localparam int              BBFC_AW          = 17;
   localparam int              BBFC_DW          = 8;
   // unlock locations and command codes
   localparam logic [16:0]     BBFC_UNLK_ADDR1  = 17'h05555;
   localparam logic [16:0]     BBFC_UNLK_ADDR2  = 17'h02aaa;
   localparam logic [7:0]      BBFC_UNLK_DATA1  = 8'haa;
   localparam logic [7:0]      BBFC_UNLK_DATA2  = 8'h55;
   localparam logic [7:0]      BBFC_CODE_PROG   = 8'ha0;
   localparam logic [7:0]      BBFC_CODE_ESETUP = 8'h80;
   localparam logic [7:0]      BBFC_CODE_CERASE = 8'h10;
   localparam logic [7:0]      BBFC_CODE_SERASE = 8'h30;
   localparam logic [7:0]      BBFC_CODE_IDENT  = 8'h90;
   localparam logic [7:0]      BBFC_CODE_RESET  = 8'hf0;
   // status bit positions in a read byte
   localparam int              BBFC_POLL_BIT    = 7;
   localparam int              BBFC_TOGGLE_BIT  = 6;
   // timing in ns and derived cycle counts
   localparam int              BBFC_CLK_NS      = 5;
   localparam int              BBFC_T_WP_NS     = 45;
   localparam int              BBFC_T_WPH_NS    = 38;
   localparam int              BBFC_T_ACC_NS    = 90;
   localparam int              BBFC_T_HV_NS     = 100;
   localparam int              BBFC_SYNC_STAGES = 2;
   localparam logic [7:0]      BBFC_WP_CYC      = 8'((BBFC_T_WP_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS);
   localparam logic [7:0]      BBFC_WPH_CYC     = 8'((BBFC_T_WPH_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS);
   localparam logic [7:0]      BBFC_RD_CYC      =
      8'((BBFC_T_ACC_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS + BBFC_SYNC_STAGES);
   localparam logic [7:0]      BBFC_HV_CYC      = 8'((BBFC_T_HV_NS + BBFC_CLK_NS - 1) / BBFC_CLK_NS);

   typedef enum logic [3:0] {
      BBFC_CMD_READ, BBFC_CMD_PROG, BBFC_CMD_SERASE, BBFC_CMD_CERASE, BBFC_CMD_AUTOSEL,
      BBFC_CMD_RESET, BBFC_CMD_LOCK, BBFC_CMD_UNLOCK, BBFC_CMD_HVID
   } bbfc_cmd_t;

   typedef struct packed {
      bbfc_cmd_t   cmd;
      logic [16:0] addr;
      logic [7:0]  data;
   } bbfc_req_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic [16:0] addr;
      logic [7:0]  dq;
      logic        dq_oe;
      logic        hv_a9;
      logic        hv_oe;
      logic        hv_ce;
   } bbfc_pins_t;

   localparam bbfc_pins_t      BBFC_PINS_IDLE   = '{1'b1, 1'b1, 1'b1, 17'h00000, 8'h00,
                                                   1'b0, 1'b0, 1'b0, 1'b0};
endpackage : bbfc_pkg

//--- tb/bbfc_flash_model.sv
module bbfc_flash_model
   import bbfc_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] DEV_CODE   = 8'h3c, // arbitrary value
   parameter int         PROG_CYC   = 100,
   parameter int         ERASE_CYC  = 200
) (
   input  wire logic       clk_sys_i,
   input  wire bbfc_pins_t pins_i,
   input  wire logic       stall_i,
   output logic [7:0]      dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem_r [int];
   bbfc_pins_t  pq_r = BBFC_PINS_IDLE;
   int          st_r = 0;
   int          busy_r = 0;
   logic        idm_r = 1'b0, lock_r = 1'b0, tog_r = 1'b0, rd_r = 1'b0;
   logic [7:0]  tgt_r = 8'hff, last_r = 8'h00, rv, d;
   logic [16:0] a;
   logic        rd;
   function automatic logic [7:0] peek(input logic [16:0] x);
      return mem_r.exists(int'(x)) ? mem_r[int'(x)] : 8'hff;
   endfunction : peek
   // read source: identification, status while busy, array otherwise
   assign rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && !pins_i.hv_oe;
   always @* begin
      if (pins_i.hv_a9 || idm_r)
         rv = (pins_i.addr[1:0] == 2'b00) ? MAKER_CODE :
              (pins_i.addr[1:0] == 2'b01) ? DEV_CODE : {7'h00, lock_r};
      else if (busy_r != 0)
         rv = {~tgt_r[7], tog_r, 6'h15};
      else
         rv = peek(pins_i.addr);
   end
   // a released bus shows the inverse of the last byte driven
   assign dq_o = rd ? rv : ~last_r;
   // write decoding, busy timer, toggle and protection state
   always @(posedge clk_sys_i) begin
      pq_r <= pins_i;
      rd_r <= rd;
      if (rd)
         last_r <= rv;
      if (rd && !rd_r && busy_r != 0)
         tog_r <= ~tog_r;
      if (busy_r != 0 && !stall_i)
         busy_r <= busy_r - 1;
      if (pins_i.hv_a9 && pins_i.hv_oe && !pins_i.we_n) begin
         if (pins_i.hv_ce)
            lock_r <= 1'b0;
         else if (!pins_i.ce_n)
            lock_r <= 1'b1;
      end
      // sampling on the clock drops strobes shorter than a cycle
      if (pins_i.we_n && !pq_r.we_n && !pq_r.ce_n && pq_r.oe_n && !pq_r.hv_oe
          && busy_r == 0) begin
         a = pq_r.addr;
         d = pq_r.dq;
         if (st_r == 6) begin
            mem_r[int'(a)] = peek(a) & d;
            tgt_r <= d;
            busy_r <= PROG_CYC;
            st_r <= 0;
         end else if (d == BBFC_CODE_RESET) begin
            st_r <= 0;
            idm_r <= 1'b0;
         end else if ((st_r == 0 || st_r == 3) && a == BBFC_UNLK_ADDR1 && d == BBFC_UNLK_DATA1)
            st_r <= st_r + 1;
         else if ((st_r == 1 || st_r == 4) && a == BBFC_UNLK_ADDR2 && d == BBFC_UNLK_DATA2)
            st_r <= st_r + 1;
         else if (st_r == 2 && a == BBFC_UNLK_ADDR1 && d == BBFC_CODE_PROG)
            st_r <= 6;
         else if (st_r == 2 && a == BBFC_UNLK_ADDR1 && d == BBFC_CODE_ESETUP)
            st_r <= 3;
         else if (st_r == 2 && a == BBFC_UNLK_ADDR1 && d == BBFC_CODE_IDENT) begin
            idm_r <= 1'b1;
            st_r <= 0;
         end else if (st_r == 5 && a == BBFC_UNLK_ADDR1 && d == BBFC_CODE_CERASE) begin
            mem_r.delete();
            tgt_r <= 8'hff;
            busy_r <= 2 * ERASE_CYC;
            st_r <= 0;
         end else if (st_r == 5 && d == BBFC_CODE_SERASE) begin
            for (int k = int'({a[16:9], 9'h000}); k < int'({a[16:9], 9'h000}) + 512; k++)
               if (mem_r.exists(k)) mem_r.delete(k);
            tgt_r <= 8'hff;
            busy_r <= ERASE_CYC;
            st_r <= 0;
         end else
            st_r <= 0;
      end
   end
endmodule : bbfc_flash_model

//--- tb/testbench.sv
module testbench
   import bbfc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int        POLL_LIM = 40;
   localparam bit [16:0] BOOT_ST  = 17'h1c002;
   logic       clk_sys_i = 1'b0, sys_rst_i = 1'b1, req_valid_i = 1'b0, stall = 1'b0;
   bbfc_req_t  req_i = '0;
   logic       req_ready_o, done_o, fail_o;
   logic [7:0] rdata_o, dq_i, dq_m;
   bbfc_pins_t pins_o;
   int         n_fail = 0, comparisons = 0;
   logic [31:0] seed = 32'h5ba09899;
   logic [7:0] exp_mem [int];
   logic [16:0] adr [6];
   logic [7:0] dat;
   bbfc_host #(.POLL_LIMIT(POLL_LIM)) uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
      .fail_o(fail_o), .rdata_o(rdata_o), .pins_o(pins_o), .dq_i(dq_i));
   bbfc_flash_model flash (.clk_sys_i(clk_sys_i), .pins_i(pins_o), .stall_i(stall), .dq_o(dq_m));
   // shared data wire: host data wins while it drives
   assign dq_i = pins_o.dq_oe ? pins_o.dq : dq_m;
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] ex(input logic [16:0] a);
      return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : 8'hff;
   endfunction : ex
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      comparisons++;
      if (seen !== expv) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check
   // one request, then wait for its completion pulse
   task automatic op(input bbfc_cmd_t c, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      // a request raised while done_o stands would be dropped
      while (req_ready_o !== 1'b1) begin
         @(posedge clk_sys_i);
         #1;
      end
      req_valid_i = 1'b1;
      req_i = '{c, a, d};
      @(posedge clk_sys_i);
      #1 req_valid_i = 1'b0;
      while (done_o !== 1'b1 && n < 30000) begin
         @(posedge clk_sys_i);
         #1 n++;
      end
      if (n >= 30000) check(8'h00, 8'h01);
   endtask : op
   task automatic rd_chk(input logic [16:0] a);
      op(BBFC_CMD_READ, a, 8'h00);
      check(rdata_o, ex(a));
   endtask : rd_chk
   task automatic summarize();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      #400us;
      n_fail++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clk_sys_i);
      #1 sys_rst_i = 1'b0;
      check({4'h0, req_ready_o, pins_o.ce_n, pins_o.we_n, pins_o.dq_oe}, 8'h0e);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         adr[i] = (i == 5) ? adr[0] : seed[16:0];
         // flash bits only go from one to zero, so a repeat write stays legal
         dat = seed[24:17] & ex(adr[i]);
         op(BBFC_CMD_PROG, adr[i], dat);
         exp_mem[int'(adr[i])] = ex(adr[i]) & dat;
         check(rdata_o, ex(adr[i]));
         check({7'h00, fail_o}, 8'h00);
         rd_chk(adr[i]);
      end
      $display("test program done");
      op(BBFC_CMD_SERASE, adr[1], 8'h00);
      check(rdata_o[7], 1'b1);
      for (int k = int'({adr[1][16:9], 9'h000}); k < int'({adr[1][16:9], 9'h000}) + 512; k++)
         if (exp_mem.exists(k)) exp_mem.delete(k);
      rd_chk(adr[1]);
      rd_chk(adr[2]);
      $display("test sector erase done");
      op(BBFC_CMD_AUTOSEL, 17'h00000, 8'h00);
      check(rdata_o, flash.MAKER_CODE);
      op(BBFC_CMD_RESET, 17'h00000, 8'h00);
      op(BBFC_CMD_AUTOSEL, 17'h00001, 8'h00);
      check(rdata_o, flash.DEV_CODE);
      op(BBFC_CMD_RESET, adr[2], 8'h00);
      rd_chk(adr[2]);
      $display("test autoselect done");
      op(BBFC_CMD_LOCK, 17'h00000, 8'h00);
      op(BBFC_CMD_HVID, BOOT_ST, 8'h00);
      check(rdata_o, 8'h01);
      op(BBFC_CMD_UNLOCK, 17'h00000, 8'h00);
      op(BBFC_CMD_HVID, BOOT_ST, 8'h00);
      check(rdata_o, 8'h00);
      op(BBFC_CMD_HVID, 17'h00000, 8'h00);
      check(rdata_o, flash.MAKER_CODE);
      rd_chk(adr[2]);
      $display("test protection done");
      op(BBFC_CMD_CERASE, 17'h00000, 8'h00);
      check(rdata_o[7], 1'b1);
      exp_mem.delete();
      rd_chk(adr[2]);
      $display("test chip erase done");
      stall = 1'b1;
      op(BBFC_CMD_PROG, adr[3], 8'h3c);
      exp_mem[int'(adr[3])] = 8'h3c;
      check({7'h00, fail_o}, 8'h01);
      stall = 1'b0;
      repeat (flash.PROG_CYC + 20) @(posedge clk_sys_i);
      #1 rd_chk(adr[3]);
      check({7'h00, fail_o}, 8'h00);
      $display("test poll timeout done");
      summarize();
   end
endmodule : testbench
